// *** core/interleaved_memory_debug_gating.sv ***
// Interleaved static memory with debug takeover gating, one top module.
// Assumes requests held until answered and the wire level resolved outside.
`timescale 1ns/10ps
module interleaved_memory_debug_gating
    import imem_pkg::*;
#(
    parameter int NUM_BANKS = BANKS_DEF,
    parameter int ROWS      = ROWS_DEF
)
(
    input  wire logic                 mclk,        // System clock
    input  wire logic                 reset,       // Async reset, high
    input  wire logic                 takeover_n,  // Debug takeover, low
    input  wire ireq_t                inst_req,    // Instruction fetch
    input  wire dreq_t                data_req,    // Load or store
    output iresp_t                    inst_resp,   // Instruction bus side
    output dresp_t                    data_resp,   // Data bus side
    output logic [NUM_BANKS-1:0]      bank_ce_n    // Bank chip enables
);
    localparam int BW = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
    localparam int RW = (ROWS > 1) ? $clog2(ROWS) : 1;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    function automatic logic [BW-1:0] bank_of(input logic [ADDR_W-1:0] a);
        return BW'(int'(a) % NUM_BANKS);
    endfunction

    function automatic logic [RW-1:0] row_of(input logic [ADDR_W-1:0] a);
        return RW'(int'(a) / NUM_BANKS);
    endfunction

    function automatic logic in_range(input logic [ADDR_W-1:0] a);
        return int'(a) < NUM_BANKS * ROWS;
    endfunction

    logic [DATA_W-1:0]    mem [NUM_BANKS][ROWS];
    logic [DATA_W-1:0]    bank_q_r [NUM_BANKS];
    state_t               state_r, state_nxt;
    logic                 ch_r, ch_nxt;
    logic [ADDR_W-1:0]    naddr_r, naddr_nxt;
    logic                 pend_r, pend_nxt;
    logic [BW-1:0]        pbank_r, pbank_nxt;
    logic                 perr_r, perr_nxt;
    logic                 pwrite_r, pwrite_nxt;
    logic                 inhibit_r, inhibit_nxt;
    iresp_t               iresp_r, iresp_nxt;
    dresp_t               dresp_r, dresp_nxt;
    logic [NUM_BANKS-1:0] ce_n_r, ce_n_nxt;

    logic                 inh_now;
    logic                 blk;
    logic                 cur_valid;
    logic                 cur_burst;
    logic                 launch;
    logic                 lch;
    logic [ADDR_W-1:0]    laddr;
    logic [BW-1:0]        lbank;
    logic                 lwrite;
    logic                 emit;

    always_comb
    begin
        // code bit 0 is the LSB, so 110 is bits 2 and 1 set
        // code 000 with takeover high leaves the memory live
        inh_now   = ~takeover_n
                  | (data_req.valid && data_req.opt == OPT_TAKEOVER);
        // registered inhibit plus the live term for the first cycle
        inhibit_nxt = inh_now;
        blk       = inh_now | inhibit_r;
        cur_valid = ch_r ? data_req.valid : inst_req.valid;
        cur_burst = ch_r ? data_req.burst : 1'b1;
        // data port wins when both ask at once
        lch       = (state_r == ST_IDLE) ? data_req.valid : ch_r;
        laddr     = (state_r != ST_IDLE) ? naddr_r
                  : (data_req.valid ? data_req.addr : inst_req.addr);
        lbank     = bank_of(laddr);
        // data port reaches the same array, writes included
        lwrite    = lch & data_req.write;
        // selection logic is disabled while blocked
        launch    = !blk
                  && ((state_r == ST_IDLE && (data_req.valid || inst_req.valid))
                  || (state_r == ST_RUN && cur_valid && cur_burst));
        emit      = (state_r == ST_RUN) && pend_r && cur_valid && !blk;
    end

    always_comb
    begin
        state_nxt = state_r;
        ch_nxt    = ch_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (launch)
                begin
                    state_nxt = ST_RUN;
                    ch_nxt    = lch;
                end
            end
            ST_RUN:
            begin
                if (!cur_valid)
                    state_nxt = ST_IDLE;
                else if (blk || !cur_burst)
                    state_nxt = ST_DRAIN;
            end
            ST_DRAIN:
            begin
                if (!cur_valid)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_comb
    begin
        // plain increment; the master re-addresses at 1K boundaries
        naddr_nxt  = launch ? ADDR_W'(laddr + 1'b1) : naddr_r;
        // word launched now is pending after the next edge and answered at the one after
        pend_nxt   = launch;
        pbank_nxt  = launch ? lbank : pbank_r;
        perr_nxt   = launch ? !in_range(laddr) : perr_r;
        pwrite_nxt = launch ? lwrite : pwrite_r;
        // enables leave a flop, so they move only on the clock edge
        for (int b = 0; b < NUM_BANKS; b++)
            ce_n_nxt[b] = !(launch && lbank == BW'(b));
    end

    always_comb
    begin
        // the bank launched last cycle drives this word
        iresp_nxt.oe      = emit && !ch_r;
        iresp_nxt.ready_n = !(emit && !ch_r);
        iresp_nxt.word    = bank_q_r[pbank_r];
        // one ready or error from whichever bank answers
        dresp_nxt.ready_oe     = emit && ch_r;
        dresp_nxt.error_oe     = emit && ch_r;
        dresp_nxt.data_ready_n = !(emit && ch_r && !perr_r);
        dresp_nxt.data_error_n = !(emit && ch_r && perr_r);
        // data lines only alongside the response lines
        dresp_nxt.bus_oe       = emit && ch_r && !pwrite_r && !perr_r;
        dresp_nxt.rdata        = bank_q_r[pbank_r];
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_r   <= ST_IDLE;
            ch_r      <= 1'b0;
            naddr_r   <= '0;
            pend_r    <= 1'b0;
            pbank_r   <= '0;
            perr_r    <= 1'b0;
            pwrite_r  <= 1'b0;
            inhibit_r <= RST_INHIBIT;
            iresp_r   <= '{oe: 1'b0, ready_n: 1'b1, word: '0};
            dresp_r   <= '{bus_oe: 1'b0, rdata: '0, data_ready_n: 1'b1,
                           ready_oe: 1'b0, data_error_n: 1'b1, error_oe: 1'b0};
            ce_n_r    <= '1;
        end
        else
        begin
            state_r   <= state_nxt;
            ch_r      <= ch_nxt;
            naddr_r   <= naddr_nxt;
            pend_r    <= pend_nxt;
            pbank_r   <= pbank_nxt;
            perr_r    <= perr_nxt;
            pwrite_r  <= pwrite_nxt;
            inhibit_r <= inhibit_nxt;
            iresp_r   <= iresp_nxt;
            dresp_r   <= dresp_nxt;
            ce_n_r    <= ce_n_nxt;
        end
    end

    // Storage carries no reset; a bank latch keeps its last read
    // each bank is only relaunched two edges after its last start
    always_ff @(posedge mclk)
    begin
        if (launch && in_range(laddr))
        begin
            if (lwrite)
                mem[lbank][row_of(laddr)] <= data_req.wdata;
            bank_q_r[lbank] <= mem[lbank][row_of(laddr)];
        end
    end

    assign inst_resp = iresp_r;
    assign data_resp = dresp_r;
    assign bank_ce_n = ce_n_r;

    a_takeover_quiet: assert property (
        !takeover_n |=> !iresp_r.oe && !dresp_r.bus_oe ##1 !iresp_r.oe)
        else $error("memory drove a bus during takeover");

    a_opt_release: assert property (
        (data_req.valid && data_req.opt == 3'h6) |=> !dresp_r.ready_oe
        && !dresp_r.error_oe && !iresp_r.oe)
        else $error("memory answered under option code 110");

    a_lines_released: assert property (
        $fell(takeover_n) |=> (!dresp_r.ready_oe && !dresp_r.error_oe)[*2])
        else $error("ready or error held while takeover low");

    a_data_with_resp: assert property (
        dresp_r.bus_oe |-> dresp_r.ready_oe && !dresp_r.data_ready_n)
        else $error("data lines driven without ready");

    a_first_latency: assert property (
        (state_r == ST_IDLE && launch && !lch) |=> !iresp_r.oe
        ##1 (iresp_r.oe || !$past(inst_req.valid) || $past(blk)))
        else $error("first word latency is not two cycles");

    a_burst_rate: assert property (
        (state_r == ST_RUN && !ch_r && pend_r && inst_req.valid && !blk)
        |=> iresp_r.oe && !iresp_r.ready_n)
        else $error("burst word missed its cycle");

    a_bank_alternate: assert property (
        (launch && $past(launch) && NUM_BANKS > 1) |-> lbank != $past(lbank))
        else $error("same bank started on consecutive cycles");

    a_even_odd_split: assert property (
        (launch && NUM_BANKS == 2) |-> lbank == BW'(laddr[0]))
        else $error("word parity does not select the bank");

    a_single_once: assert property (
        (launch && lch && !data_req.burst) |=> !launch ##1 !launch)
        else $error("single data access launched twice");

    a_resp_paired: assert property (
        dresp_r.ready_oe |-> dresp_r.error_oe
        && (dresp_r.data_ready_n != dresp_r.data_error_n))
        else $error("ready and error not answered together");

    a_ce_on_launch: assert property (
        (ce_n_r != '1) |-> $past(launch) && !$past(blk))
        else $error("chip enable without a launch");

    a_inhibit_gates: assert property (
        inhibit_r |-> !launch && !emit)
        else $error("selection active while inhibited");

    a_normal_access: assert property (
        (state_r == ST_IDLE && data_req.valid && data_req.opt == 3'h0
        && takeover_n && !inhibit_r) |-> launch)
        else $error("normal access with code 000 not started");

    a_ce_one_hot: assert property (
        $onehot0(~ce_n_r))
        else $error("two banks enabled in one cycle");

    a_blocked_no_ce: assert property (
        blk |=> (ce_n_r == '1))
        else $error("bank enabled while selection blocked");

    a_inst_ready_pair: assert property (
        iresp_r.oe == !iresp_r.ready_n)
        else $error("instruction ready not paired with drive");

    a_data_bus_idle: assert property (
        blk |=> !dresp_r.bus_oe && !dresp_r.ready_oe && !dresp_r.error_oe)
        else $error("data side active while blocked");

    a_opt_lsb_order: assert property (
        (state_r == ST_IDLE && data_req.valid && data_req.opt == 3'h3
        && takeover_n && !inhibit_r) |-> launch)
        else $error("code 011 taken as the takeover code");

    a_inhibit_set: assert property (
        (!takeover_n || (data_req.valid && data_req.opt == 3'h6)) |=> inhibit_r)
        else $error("inhibit not registered after takeover");

    a_burst_next_word: assert property (
        (launch && state_r == ST_RUN) |-> laddr == ADDR_W'($past(laddr) + 1'b1))
        else $error("burst word address did not advance by one");

    a_resp_released: assert property (
        !dresp_r.ready_oe |-> dresp_r.data_ready_n && dresp_r.data_error_n)
        else $error("released response line not at idle level");

    a_drain_no_launch: assert property (
        (state_r == ST_DRAIN) |-> !launch)
        else $error("access started while draining");

    a_single_one_ready: assert property (
        (dresp_r.ready_oe && state_r == ST_DRAIN) |=> !dresp_r.ready_oe)
        else $error("single access answered twice");

    a_emit_from_pend: assert property (
        iresp_r.oe |-> $past(pend_r))
        else $error("instruction word without a launched access");

    a_burst_stops: assert property (
        (!ch_r && !inst_req.valid) |=> !iresp_r.oe)
        else $error("instruction word after the burst ended");
endmodule

// *** shared/imem_pkg.sv ***
// Constants, types and encodings for the interleaved debug-gated memory.
// Assumes one system clock; requests are synchronous to it.
// Summary of operation
// - Even word addresses live in one bank, odd word addresses in another.
// - Bank accesses start on alternating cycles, giving each bank two cycles.
// - During a burst the banks take turns, one new word every cycle.
// - First burst word costs two cycles; every later word costs one.
// - Bank count is a parameter, so three or more banks are allowed.
// - Data requests win arbitration; single data accesses pay only first latency.
// - Bank ready and error responses are OR-combined into one response.
// - Bank chip enables change only on the clock edge.
// - The takeover input disables selection logic of every memory bank.
// - Option code 110 on a load or store stops any memory response.
// - Lowest option bit is the least significant bit of the code.
// - During takeover memories neither respond nor drive instruction or data buses.
// - Ready and error lines are released whenever takeover is low or code is 110.
// - With code 000 and takeover high the memory responds normally.
// - The data port reads and writes the instruction memory.
// - Data lines are driven only in cycles that drive ready or error.
package imem_pkg;
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 16;
    localparam int BANKS_DEF = 2;
    localparam int ROWS_DEF  = 64;
    localparam int OPT_W     = 3;
    localparam logic [OPT_W-1:0] OPT_TAKEOVER = 3'h6;
    localparam logic [OPT_W-1:0] OPT_NORMAL   = 3'h0;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RESP_LOOP_NS   = 40;
    localparam int RESP_LOOP_CYC  = RESP_LOOP_NS / CLK_PERIOD_NS;
    localparam int FIRST_LAT_CYC  = 2;
    localparam logic RST_INHIBIT  = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_RUN   = 3'h2,
        ST_DRAIN = 3'h4
    } state_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } ireq_t;

    typedef struct packed {
        logic              valid;
        logic              burst;
        logic              write;
        logic [OPT_W-1:0]  opt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dreq_t;

    typedef struct packed {
        logic              oe;
        logic              ready_n;
        logic [DATA_W-1:0] word;
    } iresp_t;

    typedef struct packed {
        logic              bus_oe;
        logic [DATA_W-1:0] rdata;
        logic              data_ready_n;
        logic              ready_oe;
        logic              data_error_n;
        logic              error_oe;
    } dresp_t;
endpackage

// *** testbench/debug_tool_model.sv ***
// Far side of the response lines: pull-ups and a debug tool that can answer.
// Assumes the memory presents ready and error as value plus enable.
`timescale 1ns/10ps
module debug_tool_model
    import imem_pkg::*;
(
    input  wire dresp_t data_resp, // Memory response pins
    input  wire logic   dbg_drive, // Tool answers instead of memory
    output logic        ready_w,   // Resolved ready wire
    output logic        error_w    // Resolved error wire
);
    // released lines float to the pull-up
    assign ready_w = ~((data_resp.ready_oe & ~data_resp.data_ready_n) | dbg_drive);
    assign error_w = ~(data_resp.error_oe & ~data_resp.data_error_n);
endmodule

// *** testbench/interleaved_memory_debug_gating_bench.sv ***
// Self-checking bench for the interleaved debug-gated memory.
// Assumes the package constants and the tool model beside it.
`timescale 1ns/10ps
module interleaved_memory_debug_gating_bench;
    import imem_pkg::*;
    logic         mclk       = 1'b0;
    logic         reset      = 1'b1;
    logic         takeover_n = 1'b1;
    logic         dbg_drive  = 1'b0;
    ireq_t        inst_req   = '0;
    dreq_t        data_req   = '0;
    iresp_t       inst_resp;
    dresp_t       data_resp;
    logic [1:0]   bank_ce_n;
    logic         ready_w;
    logic         error_w;
    int           miscompares  = 0;
    int           total_checks = 0;
    int           cycles       = 0;
    int           n;

    interleaved_memory_debug_gating #(.NUM_BANKS(2), .ROWS(64)) u_dut (
        .mclk(mclk), .reset(reset), .takeover_n(takeover_n), .inst_req(inst_req),
        .data_req(data_req), .inst_resp(inst_resp), .data_resp(data_resp),
        .bank_ce_n(bank_ce_n));
    debug_tool_model u_tool (.data_resp(data_resp), .dbg_drive(dbg_drive),
        .ready_w(ready_w), .error_w(error_w));

    always #5 mclk = ~mclk;

    function automatic logic [DATA_W-1:0] pat(input int i);
        return 32'hA5A50000 + DATA_W'(i);
    endfunction

    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, far above the fewer than 100 cycles the run needs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Single access; returns with the answer on the pins or after 6 edges, n edges counted
    task data_op(input logic wr, input logic [OPT_W-1:0] op, input int ad, output int k);
        k = 0;
        @(posedge mclk) data_req <= '{1'b1, 1'b0, wr, op, ADDR_W'(ad), pat(ad)};
        while (data_resp.ready_oe !== 1'b1 && k < 6)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask

    task data_end();
        @(posedge mclk) data_req.valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task write_read();
        // never mix reads and writes in one burst
        for (int i = 4; i < 8; i++)
        begin
            data_op(1'b1, OPT_NORMAL, i, n);
            chk(n, FIRST_LAT_CYC);
            data_end();
        end
        // Code 011 must not be read as 110 with the bits reversed
        data_op(1'b0, 3'h3, 5, n);
        chk(data_resp.rdata, pat(5));
        chk(ready_w, 1'b0);
        chk(data_resp.bus_oe, 1'b1);
        data_end();
    endtask

    task burst_fetch();
        @(posedge mclk) inst_req <= '{1'b1, 16'h0004};
        @(posedge mclk);
        #1 chk(bank_ce_n[0], 1'b0);
        @(posedge mclk);
        #1 chk(bank_ce_n[1], 1'b0);
        // First word rides out with the second bank's enable
        for (int k = 0; k < 4; k++)
        begin
            chk(inst_resp.oe, 1'b1);
            chk(inst_resp.ready_n, 1'b0);
            chk(inst_resp.word, pat(4 + k));
            if (k < 3)
            begin
                @(posedge mclk);
                #1;
            end
        end
        @(posedge mclk) inst_req.valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task takeover_pin();
        @(posedge mclk)
        begin
            takeover_n <= 1'b0;
            inst_req   <= '{1'b1, 16'h0004};
        end
        repeat (6)
        begin
            @(posedge mclk);
            #1 chk(inst_resp.oe, 1'b0);
            chk(bank_ce_n, 2'h3);
            chk(ready_w, 1'b1);
        end
        @(posedge mclk)
        begin
            takeover_n     <= 1'b1;
            inst_req.valid <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask

    task option_code();
        data_op(1'b0, OPT_TAKEOVER, 5, n);
        chk(n, 6);
        chk(data_resp.bus_oe, 1'b0);
        @(posedge mclk) dbg_drive <= 1'b1;
        @(posedge mclk);
        #1 chk(ready_w, 1'b0);
        chk(data_resp.ready_oe, 1'b0);
        chk(data_resp.error_oe, 1'b0);
        @(posedge mclk)
        begin
            dbg_drive      <= 1'b0;
            data_req.valid <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask

    task out_of_range();
        // First word past both banks of 64 rows
        data_op(1'b0, OPT_NORMAL, 128, n);
        chk(n, FIRST_LAT_CYC);
        chk(error_w, 1'b0);
        chk(ready_w, 1'b1);
        chk(data_resp.bus_oe, 1'b0);
        data_end();
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        write_read();
        burst_fetch();
        takeover_pin();
        option_code();
        out_of_range();
        report_and_stop();
    end
endmodule
